// file: src/irct_pkg.sv
// Purpose: Shared constants and types for the infrared carrier timer.
// Assumes: One word per register; byte address is four times the index.
// Notes:   Carrier and init figures count aclk cycles; tau figures count carrier periods.
package irct_pkg;

    // ------------------------------------------------------------------
    // Bus layout
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [7:0] IDX_FLAGS    = 8'hF0;
    localparam logic [7:0] IDX_CONTROL  = 8'hF2;
    localparam logic [7:0] IDX_CARRIER  = 8'hF7;
    localparam logic [7:0] IDX_INTERVAL = 8'hF8;
    localparam logic [7:0] IDX_WIDTH    = 8'hF9;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned BIT_FORCED = 3;
    localparam int unsigned BIT_FLAG   = 2;
    localparam int unsigned BIT_ENABLE = 3;
    localparam int unsigned BIT_MASK   = 2;
    localparam logic       RST_ENABLE   = 1'b1;
    localparam logic [3:0] IC_IDLE      = 4'hF;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned INIT_CYCLES = 32;
    localparam logic [3:0] CAR_PER_8    = 4'h8;
    localparam logic [3:0] CAR_PER_12   = 4'hC;
    localparam logic [3:0] CAR_HI_2     = 4'h2;
    localparam logic [3:0] CAR_HI_3     = 4'h3;
    localparam logic [3:0] CAR_HI_4     = 4'h4;
    localparam logic [5:0] TAU_PER_12   = 6'h0C;
    localparam logic [5:0] TAU_PER_16   = 6'h10;
    localparam logic [5:0] TAU_PER_20   = 6'h14;
    localparam logic [5:0] TAU_PER_32   = 6'h20;

    typedef struct packed {
        logic       div;
        logic       duty;
        logic [1:0] tau_sel;
    } irct_cfg_t;

endpackage

// file: src/irct_timer.sv
// Purpose: Carrier, reference period, output width and interval counter.
// Assumes: aclk is the fast oscillator; registers reached over AXI4-Lite.
// Notes:   Register data sits in bits 3:0; upper bits read as zero.
// Summary of operation
// - Interrupt follows counter expiry two cycles later.
// - Interrupt comes n tau after counter load.
// - Mask bit gates the interrupt request.
// - Expiry sets flag; reading the flag clears it.
// - Output follows tau without processor help.
// - Enable held at one during initialization.
// - Clearing enable stops at next tau boundary.
// - Two bits pick carrier division and duty.
// - Two bits pick tau as carrier division.
// - Each nonzero width write gives one timed burst.
// - Counter steps per tau; stepping from 0 sets flag and leaves it idle at 0FH.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
module irct_timer (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write address and data
    input  wire logic [irct_pkg::ADDR_W-1:0] s_axil_awaddr,
    input  wire logic                       s_axil_awvalid,
    output logic                            s_axil_awready,
    input  wire logic [31:0]                s_axil_wdata,
    input  wire logic [3:0]                 s_axil_wstrb,
    input  wire logic                       s_axil_wvalid,
    output logic                            s_axil_wready,
    // AXI4-Lite write response
    output logic [1:0]                      s_axil_bresp,
    output logic                            s_axil_bvalid,
    input  wire logic                       s_axil_bready,
    // AXI4-Lite read
    input  wire logic [irct_pkg::ADDR_W-1:0] s_axil_araddr,
    input  wire logic                       s_axil_arvalid,
    output logic                            s_axil_arready,
    output logic [31:0]                     s_axil_rdata,
    output logic [1:0]                      s_axil_rresp,
    output logic                            s_axil_rvalid,
    input  wire logic                       s_axil_rready,
    // Emitter and processor interrupt
    output logic                            ir_carrier_output,
    output logic                            carrier_irq
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic                      awready_q, wready_q, bvalid_q, arready_q;
    logic                      rvalid_q, aw_full_q, w_full_q;
    logic [1:0]                bresp_q, rresp_q;
    logic [31:0]               rdata_q;
    logic [irct_pkg::ADDR_W-1:0] waddr_q;
    logic [3:0]                wdata_q;
    logic                      wstrb_q;
    logic                      forced_output_q, carrier_irq_flag_q;
    logic                      carrier_enable_q, carrier_irq_mask_q;
    irct_pkg::irct_cfg_t       cfg_q;
    logic [3:0]                ic_hold_q, irq_interval_counter_q;
    logic                      ic_pend_q, ow_pend_q;
    logic [1:0]                output_width_setting_q, ow_rem_q;
    logic                      run_q, out_q, irq_q;
    logic [5:0]                init_cnt_q;
    logic [3:0]                car_cnt_q;
    logic [5:0]                tau_cnt_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire       aw_take = s_axil_awvalid && awready_q;
    wire       w_take  = s_axil_wvalid && wready_q;
    wire       ar_take = s_axil_arvalid && arready_q;
    wire       wr_go   = aw_full_q && w_full_q && !bvalid_q;
    wire [7:0] widx    = waddr_q[9:2];
    wire [7:0] ridx    = s_axil_araddr[9:2];
    wire       w_hi0   = waddr_q[11:10] == 2'b00;
    wire       r_hi0   = s_axil_araddr[11:10] == 2'b00;
    wire       wr_en   = wr_go && wstrb_q && w_hi0;
    wire       wr_flags = wr_en && widx == irct_pkg::IDX_FLAGS;
    wire       wr_ctrl  = wr_en && widx == irct_pkg::IDX_CONTROL;
    wire       wr_car   = wr_en && widx == irct_pkg::IDX_CARRIER;
    wire       wr_ic    = wr_en && widx == irct_pkg::IDX_INTERVAL;
    wire       wr_ow    = wr_en && widx == irct_pkg::IDX_WIDTH;
    wire       w_map    = w_hi0 && (widx == irct_pkg::IDX_FLAGS
                          || widx == irct_pkg::IDX_CONTROL
                          || widx == irct_pkg::IDX_CARRIER
                          || widx == irct_pkg::IDX_INTERVAL
                          || widx == irct_pkg::IDX_WIDTH);
    wire       r_flags = r_hi0 && ridx == irct_pkg::IDX_FLAGS;
    wire       r_ctrl  = r_hi0 && ridx == irct_pkg::IDX_CONTROL;
    wire       r_car   = r_hi0 && ridx == irct_pkg::IDX_CARRIER;
    wire       r_ic    = r_hi0 && ridx == irct_pkg::IDX_INTERVAL;
    wire       r_ow    = r_hi0 && ridx == irct_pkg::IDX_WIDTH;
    wire       r_map   = r_flags || r_ctrl || r_car || r_ic || r_ow;
    wire       read_flag = ar_take && r_flags;
    wire [3:0] rd_val =
        r_flags ? {forced_output_q, carrier_irq_flag_q, 2'b00} :
        r_ctrl  ? {carrier_enable_q, carrier_irq_mask_q, 2'b00} :
        r_car   ? cfg_q :
        r_ic    ? irq_interval_counter_q :
        r_ow    ? {2'b00, output_width_setting_q} : 4'h0;

    // ------------------------------------------------------------------
    // Carrier and tau timing
    // ------------------------------------------------------------------
    wire [3:0] car_per = cfg_q.div ? irct_pkg::CAR_PER_12
                                   : irct_pkg::CAR_PER_8;
    wire [3:0] car_hi  =
        ({cfg_q.div, cfg_q.duty} == 2'b00) ? irct_pkg::CAR_HI_2 :
        ({cfg_q.div, cfg_q.duty} == 2'b10) ? irct_pkg::CAR_HI_4 :
                                             irct_pkg::CAR_HI_3;
    wire [5:0] tau_per =
        (cfg_q.tau_sel == 2'b00) ? irct_pkg::TAU_PER_12 :
        (cfg_q.tau_sel == 2'b01) ? irct_pkg::TAU_PER_16 :
        (cfg_q.tau_sel == 2'b10) ? irct_pkg::TAU_PER_20 :
                                   irct_pkg::TAU_PER_32;
    wire       car_wrap = run_q && car_cnt_q == car_per - 4'h1;
    wire       tau_rise = car_wrap && tau_cnt_q == tau_per - 6'h01;
    wire       car_on   = run_q && car_cnt_q < car_hi;
    wire       init_done = init_cnt_q == 6'(irct_pkg::INIT_CYCLES);
    wire [3:0] ic_src   = ic_pend_q ? ic_hold_q : irq_interval_counter_q;
    wire       ic_step  = tau_rise
                          && (ic_pend_q || ic_src != irct_pkg::IC_IDLE);
    wire       flag_set = ic_step && ic_src == 4'h0;
    wire [1:0] ow_len   = {output_width_setting_q[1], 1'b0}
                          + {1'b0, output_width_setting_q[0]};
    wire       out_d    = car_on && (ow_rem_q != 2'b00 || forced_output_q);
    wire       car_rst  = !run_q || car_wrap
                          || (wr_flags && wdata_q[irct_pkg::BIT_FORCED]);

    // ------------------------------------------------------------------
    // AXI4-Lite channels
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= irct_pkg::RESP_OKAY;
            waddr_q   <= '0;
            wdata_q   <= 4'h0;
            wstrb_q   <= 1'b0;
        end else begin
            if (aw_take) begin
                awready_q <= 1'b0;
                aw_full_q <= 1'b1;
                waddr_q   <= s_axil_awaddr;
            end
            if (w_take) begin
                wready_q <= 1'b0;
                w_full_q <= 1'b1;
                wdata_q  <= s_axil_wdata[3:0];
                wstrb_q  <= s_axil_wstrb[0];
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= w_map ? irct_pkg::RESP_OKAY
                                   : irct_pkg::RESP_SLVERR;
            end
            if (bvalid_q && s_axil_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= irct_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {28'h000_0000, rd_val};
            rresp_q   <= r_map ? irct_pkg::RESP_OKAY : irct_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axil_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            forced_output_q    <= 1'b0;
            carrier_enable_q   <= irct_pkg::RST_ENABLE;
            carrier_irq_mask_q <= 1'b0;
            cfg_q              <= '0;
            init_cnt_q         <= 6'h00;
        end else begin
            if (!init_done)
                init_cnt_q <= init_cnt_q + 6'h01;
            if (wr_flags)
                forced_output_q <= wdata_q[irct_pkg::BIT_FORCED];
            if (wr_ctrl) begin
                carrier_irq_mask_q <= wdata_q[irct_pkg::BIT_MASK];
                if (init_done || wdata_q[irct_pkg::BIT_ENABLE])
                    carrier_enable_q <= wdata_q[irct_pkg::BIT_ENABLE];
            end
            if (wr_car)
                cfg_q <= irct_pkg::irct_cfg_t'(wdata_q);
        end
    end

    // ------------------------------------------------------------------
    // Carrier generator, width burst and interval counter
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q     <= 1'b0;
            car_cnt_q <= 4'h0;
            tau_cnt_q <= 6'h00;
        end else begin
            if (carrier_enable_q)
                run_q <= 1'b1;
            else if (tau_rise)
                run_q <= 1'b0;
            if (car_rst)
                car_cnt_q <= 4'h0;
            else
                car_cnt_q <= car_cnt_q + 4'h1;
            if (!run_q || tau_rise)
                tau_cnt_q <= 6'h00;
            else if (car_wrap)
                tau_cnt_q <= tau_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_width_setting_q <= 2'b00;
            ow_pend_q              <= 1'b0;
            ow_rem_q               <= 2'b00;
        end else begin
            if (wr_ow)
                output_width_setting_q <= wdata_q[1:0];
            if (wr_ow)
                ow_pend_q <= 1'b1;
            else if (tau_rise)
                ow_pend_q <= 1'b0;
            if (!run_q)
                ow_rem_q <= 2'b00;
            else if (tau_rise && ow_pend_q)
                ow_rem_q <= ow_len;
            else if (tau_rise && ow_rem_q != 2'b00)
                ow_rem_q <= ow_rem_q - 2'b01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ic_hold_q              <= 4'h0;
            ic_pend_q              <= 1'b0;
            irq_interval_counter_q <= irct_pkg::IC_IDLE;
        end else begin
            if (wr_ic)
                ic_hold_q <= wdata_q;
            if (wr_ic)
                ic_pend_q <= 1'b1;
            else if (tau_rise)
                ic_pend_q <= 1'b0;
            if (ic_step)
                irq_interval_counter_q <= ic_src - 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Flag, interrupt and pin
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carrier_irq_flag_q <= 1'b0;
            irq_q              <= 1'b0;
            out_q              <= 1'b0;
        end else begin
            if (flag_set)
                carrier_irq_flag_q <= 1'b1;
            else if (read_flag)
                carrier_irq_flag_q <= 1'b0;
            irq_q <= carrier_irq_flag_q && carrier_irq_mask_q;
            out_q <= out_d;
        end
    end

    assign s_axil_awready    = awready_q;
    assign s_axil_wready     = wready_q;
    assign s_axil_bvalid     = bvalid_q;
    assign s_axil_bresp      = bresp_q;
    assign s_axil_arready    = arready_q;
    assign s_axil_rvalid     = rvalid_q;
    assign s_axil_rdata      = rdata_q;
    assign s_axil_rresp      = rresp_q;
    assign ir_carrier_output = out_q;
    assign carrier_irq       = irq_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_IRQ_FOLLOWS: assert property (flag_set && carrier_irq_mask_q |-> ##2 carrier_irq) else $error("irq late");
    AST_IRQ_MASKED: assert property (!carrier_irq_mask_q |=> !carrier_irq) else $error("irq not masked");
    AST_FLAG_SET: assert property (flag_set |=> carrier_irq_flag_q) else $error("flag not set");
    AST_READ_CLEAR: assert property (read_flag && !flag_set |=> !carrier_irq_flag_q) else $error("flag kept");
    AST_IC_LOAD: assert property (tau_rise && ic_pend_q |=> irq_interval_counter_q == $past(ic_hold_q) - 4'h1) else $error("bad load");
    AST_STOP_TAU: assert property (run_q && !tau_rise |=> run_q) else $error("early stop");
    AST_INIT_HOLD: assert property (!init_done |-> carrier_enable_q) else $error("enable dropped");
    AST_WIDTH: assert property (tau_rise && ow_pend_q && run_q ##1 run_q |-> ow_rem_q == $past(ow_len)) else $error("bad width");
    AST_CAR_RANGE: assert property (car_cnt_q < car_per) else $error("carrier count");
    AST_TAU_RANGE: assert property (tau_cnt_q < tau_per) else $error("tau count");
    AST_PIN_IDLE: assert property (!run_q |=> !ir_carrier_output) else $error("pin active");

endmodule

// file: verif/irct_emitter.sv
// Purpose: Infrared emitter model that measures the carrier pin.
// Assumes: The pin is active high and sampled on aclk.
// Notes:   Counts pulses and keeps the last high time and period.
module irct_emitter (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Pin and measurement control
    input  wire logic ir_carrier_output,
    input  wire logic clr,
    // Measurements
    output int        pulses,
    output int        hi_len,
    output int        period
);
    timeunit 1ns;
    timeprecision 1ns;

    logic prev_q;
    int   hi_cnt;
    int   per_cnt;

    // The first period after a clear is not meaningful; later ones are.
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            prev_q  <= 1'b0;
            pulses  <= 0;
            hi_len  <= 0;
            period  <= 0;
            hi_cnt  <= 0;
            per_cnt <= 0;
        end else begin
            prev_q  <= ir_carrier_output;
            per_cnt <= per_cnt + 1;
            hi_cnt  <= hi_cnt + 1;
            if (ir_carrier_output && !prev_q) begin
                pulses  <= pulses + 1;
                period  <= per_cnt;
                per_cnt <= 1;
                hi_cnt  <= 1;
            end
            if (!ir_carrier_output && prev_q) begin
                hi_len <= hi_cnt;
            end
        end
    end
endmodule

// file: verif/test_irct_timer.sv
// Purpose: Self-checking bench for the infrared carrier timer.
// Assumes: Register effects land with the write response.
// Notes:   Carrier pulses are measured by the emitter model.
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("Error at %0t: got %0h expected %0h", $time, (got), \
                     (exp)); \
        end \
    end

module test_irct_timer;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int         AW  = irct_pkg::ADDR_W;
    localparam logic [7:0] FLG = irct_pkg::IDX_FLAGS;
    localparam logic [7:0] CTL = irct_pkg::IDX_CONTROL;
    localparam logic [7:0] CAR = irct_pkg::IDX_CARRIER;
    localparam logic [7:0] ICN = irct_pkg::IDX_INTERVAL;
    localparam logic [7:0] WID = irct_pkg::IDX_WIDTH;

    logic          aclk;
    logic          aresetn;
    logic [AW-1:0] awaddr;
    logic          awvalid;
    logic          awready;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          wvalid;
    logic          wready;
    logic [1:0]    bresp;
    logic          bvalid;
    logic          bready;
    logic [AW-1:0] araddr;
    logic          arvalid;
    logic          arready;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          rvalid;
    logic          rready;
    logic          ir_out;
    logic          irq;
    logic          clr;
    int            pulses;
    int            hi_len;
    int            period;
    int            num_errors;
    int            samples_checked;
    logic [1:0]    resp;
    logic [31:0]   rd;
    int            cyc;
    int            w;
    int            tn_tab[4] = '{12, 16, 20, 32};
    int            hi_tab[4] = '{2, 3, 4, 3};
    logic [3:0]    nv[4] = '{4'h0, 4'h1, 4'h3, 4'hE};

    irct_timer i_dut (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .s_axil_awaddr     (awaddr),
        .s_axil_awvalid    (awvalid),
        .s_axil_awready    (awready),
        .s_axil_wdata      (wdata),
        .s_axil_wstrb      (wstrb),
        .s_axil_wvalid     (wvalid),
        .s_axil_wready     (wready),
        .s_axil_bresp      (bresp),
        .s_axil_bvalid     (bvalid),
        .s_axil_bready     (bready),
        .s_axil_araddr     (araddr),
        .s_axil_arvalid    (arvalid),
        .s_axil_arready    (arready),
        .s_axil_rdata      (rdata),
        .s_axil_rresp      (rresp),
        .s_axil_rvalid     (rvalid),
        .s_axil_rready     (rready),
        .ir_carrier_output (ir_out),
        .carrier_irq       (irq)
    );

    irct_emitter i_emit (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .ir_carrier_output (ir_out),
        .clr               (clr),
        .pulses            (pulses),
        .hi_len            (hi_len),
        .period            (period)
    );

    task automatic wr(input logic [7:0] idx, input logic [3:0] val);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= AW'({idx, 2'h0});
        wdata   <= {28'h0, val};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 500);
        resp = bresp;
        bready <= 1'b0;
        if (n >= 500) num_errors++;
    endtask

    task automatic rdr(input logic [7:0] idx);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= AW'({idx, 2'h0});
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 500);
        rd   = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n >= 500) num_errors++;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic pclr;
        @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
    endtask

    task automatic close_out;
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    initial begin
        repeat (40000) @(posedge aclk);
        num_errors++;
        close_out();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb           = 4'hF;
        num_errors      = 0;
        samples_checked = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // An enable clear during initialization must be ignored.
        wr(CTL, 4'h0);
        rdr(CTL);
        `CHK(rd, 32'h8)
        wr(CAR, 4'h0);
        wr(ICN, 4'h0);
        waitc(2 * 96);
        rdr(FLG);
        rdr(FLG);
        `CHK(rd, 32'h0)
        wr(8'h10, 4'h1);
        `CHK(resp, irct_pkg::RESP_SLVERR)
        rdr(8'h10);
        `CHK(resp, irct_pkg::RESP_SLVERR)
        // A write with its low strobe clear leaves the register alone.
        wstrb <= 4'h0;
        wr(CTL, 4'hC);
        wstrb <= 4'hF;
        `CHK(resp, irct_pkg::RESP_OKAY)
        rdr(CTL);
        `CHK(rd, 32'h8)
        // Every carrier and tau selection, with a timed burst each.
        for (int i = 0; i < 4; i++) begin
            w = (i == 3) ? 3 : i + 1;
            wr(CTL, 4'h0);
            waitc(400);
            wr(CAR, {i[1:0], i[1:0]});
            wr(CTL, 4'h8);
            pclr();
            wr(WID, 4'(w));
            waitc((w + 2) * tn_tab[i] * (i[1] ? 12 : 8));
            `CHK(pulses, w * tn_tab[i])
            `CHK(hi_len, hi_tab[i])
            `CHK(period, (i[1] ? 12 : 8))
            rdr(CAR);
            `CHK(rd, {28'h0, i[1:0], i[1:0]})
        end
        pclr();
        wr(WID, 4'h0);
        waitc(3 * 384);
        `CHK(pulses, 0)
        // A running carrier stops within one tau of the enable clear.
        wr(FLG, 4'h8);
        waitc(400);
        `CHK(pulses > 0, 1'b1)
        wr(CTL, 4'h0);
        waitc(390);
        pclr();
        waitc(400);
        `CHK(pulses, 0)
        wr(FLG, 4'h0);
        wr(CAR, 4'h0);
        wr(CTL, 4'hC);
        foreach (nv[k]) begin
            wr(ICN, nv[k]);
            cyc = 0;
            while (irq !== 1'b1 && cyc < 2000) begin
                @(posedge aclk);
                cyc++;
            end
            `CHK(cyc >= nv[k] * 96 && cyc <= nv[k] * 96 + 98, 1'b1)
            rdr(ICN);
            `CHK(rd, 32'hF)
            rdr(FLG);
            `CHK(rd, 32'h4)
            rdr(FLG);
            `CHK(rd, 32'h0)
            `CHK(irq, 1'b0)
        end
        // With the mask clear the flag sets but no request is raised.
        wr(CTL, 4'h8);
        wr(ICN, 4'h1);
        cyc = 0;
        repeat (300) begin
            @(posedge aclk);
            if (irq !== 1'b0) cyc++;
        end
        `CHK(cyc, 0)
        rdr(FLG);
        `CHK(rd, 32'h4)
        close_out();
    end
endmodule
